// ==== bench/core_model.sv ====
// CPU core, interrupt controller and watchdog timer as seen by the power manager.
// Assumes the bench calls its tasks on the pclk domain; fire_wdt is also called in sleep, while the CPU clock is stopped.
`timescale 1ns/10ps
module core_model
   import pm_pkg::*;
(
   input  wire logic pclk,
   input  wire logic cpu_resume,
   output core_req_t core_req,
   output logic      wdt_timeout
);
   // Nothing is requested until the bench asks for it.
   initial begin
      core_req = '0;
      wdt_timeout = 1'b0;
   end

   // The power-save instruction is one cycle long; an interrupt may coincide with it.
   task automatic exec_psave(input logic idle, input logic with_irq);
      @(posedge pclk);
      core_req.psave <= 1'b1;
      core_req.psave_idle <= idle;
      if (with_irq) core_req.irq <= 1'b1;
      @(posedge pclk);
      core_req.psave <= 1'b0;
   endtask : exec_psave

   // Interrupt request level, set or dropped at a clock edge.
   task automatic set_irq(input logic v);
      @(posedge pclk);
      core_req.irq <= v;
   endtask : set_irq

   // The timer raises its timeout and keeps it until the CPU restarts.
   task automatic fire_wdt;
      @(posedge pclk);
      wdt_timeout <= 1'b1;
   endtask : fire_wdt

   // The handler and the timer reload acknowledge on restart, so requests do not linger.
   always @(posedge pclk) begin
      if (cpu_resume) begin
         core_req.irq <= 1'b0;
         wdt_timeout <= 1'b0;
      end
   end
endmodule : core_model

// ==== bench/power_saving_clock_manager_tb.sv ====
// Self-checking bench of the power manager: registers, sleep, idle, slowdown and disables.
// Assumes core_model drives the core side and pm_defines.svh is on the include path.
`timescale 1ns/10ps
`include "pm_defines.svh"
module power_saving_clock_manager_tb
   import pm_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr, pclk_en, preg_en;
   logic [31:0] pwdata, prdata, rd;
   logic        wdt_enable, clock_failure_monitor_enable, locked, clock_failure_monitor_active, wdt_clear, cpu_resume, wdt_timeout, sw_done;
   logic [2:0]  osc_request;
   core_req_t   core_req;
   clk_gate_t   clk_gate;
   int          n_mismatch, n_compared, n;

   // Bit 7 absent and bit 0 externally clocked, so both parameters are exercised.
   power_saving_clock_manager #(.PRESENT(8'h7f), .EXT_CLOCKED(8'h01)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .core_req(core_req), .wdt_timeout(wdt_timeout), .wdt_enable(wdt_enable),
      .clock_failure_monitor_enable(clock_failure_monitor_enable), .clock_config_locked(locked), .clk_switch_done(sw_done),
      .clk_gate(clk_gate), .clock_failure_monitor_active(clock_failure_monitor_active), .wdt_clear(wdt_clear),
      .cpu_resume(cpu_resume), .osc_request(osc_request), .periph_clk_en(pclk_en),
      .periph_reg_en(preg_en));

   core_model u_core (.pclk(pclk), .cpu_resume(cpu_resume), .core_req(core_req), .wdt_timeout(wdt_timeout));

   // 20 MHz system clock.
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   task automatic stop_test;
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Waits n edges and lets their updates land before anything is sampled.
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : tick

   // One APB transfer; request held until pready is sampled high, then released.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (k == 16) chk(32'h0, 32'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Counts settled cycles until the restart pulse, bounded so a stuck state is reported.
   task automatic wait_resume;
      n = 0;
      do begin
         tick(1);
         n++;
      end while (cpu_resume !== 1'b1 && n < 50);
   endtask : wait_resume

   task automatic t_reset;
      tick(1);
      chk(clk_gate, 4'b1110);
      chk(pclk_en, 8'h7f);
      apb(1'b0, `CDIV_OFFSET, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
   endtask : t_reset

   task automatic t_osc;
      @(posedge pclk) locked <= 1'b1;
      apb(1'b1, `OSCC_OFFSET, 32'h500);
      tick(1);
      chk(osc_request, 3'h0);
      @(posedge pclk) locked <= 1'b0;
      apb(1'b1, `OSCC_OFFSET, 32'h500);
      tick(1);
      chk(osc_request, 3'h5);
      // A completed switch makes the requested source the current one.
      @(posedge pclk) sw_done <= 1'b1;
      @(posedge pclk) sw_done <= 1'b0;
      apb(1'b0, `OSCC_OFFSET, 32'h0);
      chk(rd, 32'h5500);
   endtask : t_osc

   // Idle entered with an interrupt riding on the instruction itself.
   task automatic t_idle;
      @(posedge pclk) clock_failure_monitor_enable <= 1'b1;
      u_core.exec_psave(1'b1, 1'b1);
      #1;
      chk(wdt_clear, 1'b1);
      tick(1);
      chk(clk_gate, 4'b1011);
      chk(pclk_en, 8'h7f);
      wait_resume();
      chk(n, `WAKE_CYCLES + 1);
      chk(clk_gate.cpu, 1'b1);
      apb(1'b0, `RCAUSE_OFFSET, 32'h0);
      chk(rd, 32'h4);
      apb(1'b1, `RCAUSE_OFFSET, 32'h0);
      apb(1'b0, `RCAUSE_OFFSET, 32'h0);
      chk(rd, 32'h0);
   endtask : t_idle

   // Sleep left by a watchdog timeout, then idle cut short by a device reset.
   task automatic t_sleep;
      @(posedge pclk) wdt_enable <= 1'b1;
      u_core.exec_psave(1'b0, 1'b0);
      tick(1);
      chk(clk_gate, 4'b0001);
      chk(clock_failure_monitor_active, 1'b0);
      chk(pclk_en, 8'h01);
      u_core.fire_wdt();
      wait_resume();
      chk(n < 8, 1'b1);
      chk(clk_gate, 4'b1111);
      chk(osc_request, 3'h5);
      apb(1'b0, `OSCC_OFFSET, 32'h0);
      chk(rd, 32'h5500);
      u_core.exec_psave(1'b1, 1'b0);
      tick(1);
      chk(clk_gate, 4'b1011);
      @(posedge pclk) presetn <= 1'b0;
      tick(1);
      chk(clk_gate, 4'b1110);
      @(posedge pclk) presetn <= 1'b1;
   endtask : t_sleep

   task automatic t_pcoff;
      apb(1'b1, `PCOFF_OFFSET, 32'h85);
      #1;
      chk(pclk_en, 8'h7f);
      tick(1);
      chk(pclk_en, 8'h7a);
      chk(preg_en, 8'h7a);
      apb(1'b1, `PCOFF_OFFSET, 32'h0);
      tick(1);
      chk(pclk_en, 8'h7f);
   endtask : t_pcoff

   // Counts CPU enables over 128 cycles, a whole number of periods for every ratio.
   task automatic count_cpu(input int exp);
      int c;
      c = 0;
      tick(16);
      repeat (128) begin
         tick(1);
         if (clk_gate.cpu === 1'b1) c++;
      end
      chk(c, exp);
      chk(pclk_en, 8'h7f);
   endtask : count_cpu

   task automatic t_slow;
      for (int r = 0; r < 8; r++) begin
         apb(1'b1, `CDIV_OFFSET, {16'h0, 1'b0, 3'(r), 1'b1, 11'h0});
         count_cpu(128 >> r);
      end
      apb(1'b1, `CDIV_OFFSET, 32'h3000);
      count_cpu(128);
      apb(1'b1, `CDIV_OFFSET, 32'h2800);
      u_core.set_irq(1'b1);
      tick(2);
      apb(1'b0, `CDIV_OFFSET, 32'h0);
      chk(rd, 32'h2800);
      apb(1'b1, `CDIV_OFFSET, 32'ha800);
      tick(2);
      apb(1'b0, `CDIV_OFFSET, 32'h0);
      chk(rd, 32'ha000);
      u_core.set_irq(1'b0);
   endtask : t_slow

   // Main sequence after ten cycles of reset.
   initial begin
      n_mismatch = 0;
      n_compared = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      wdt_enable = 1'b0;
      clock_failure_monitor_enable = 1'b0;
      locked = 1'b0;
      sw_done = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_osc();
      t_idle();
      t_sleep();
      t_pcoff();
      t_slow();
      stop_test();
   end

   // The tests need under 2000 cycles; a hang past 4000 is reported as a mismatch.
   initial begin
      #(4000 * 50);
      n_mismatch++;
      stop_test();
   end
endmodule : power_saving_clock_manager_tb

// ==== rtl/cpu_slowdown_divider.sv ====
// Produces a one-cycle CPU clock-enable tick every 2**ratio system clocks.
// Assumes ratio and enable come from logic on the same pclk domain.
`timescale 1ns/10ps
`include "pm_defines.svh"

module cpu_slowdown_divider
   import pm_pkg::*;
#(
   parameter int RATIO_W = 3,
   parameter int CNT_W   = 7
)(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               enable,
   input  wire logic [RATIO_W-1:0] ratio,
   output logic                    tick_q
);

   logic [CNT_W-1:0]   cnt_q;
   logic [RATIO_W-1:0] ratio_q;
   logic               wrap;

   // Terminal count mask for a given power-of-two ratio.
   function automatic logic [CNT_W-1:0] ratio_mask(input logic [RATIO_W-1:0] r);
      ratio_mask = CNT_W'((1 << r) - 1);
   endfunction : ratio_mask

   assign wrap = (cnt_q == ratio_mask(ratio_q));

   // The ratio is taken only at a period boundary so a change never yields a short pulse.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ratio_q <= `RATIO_RESET;
      end else if (!enable || wrap) begin
         ratio_q <= ratio;
      end
   end

   // Free counter; it restarts whenever slowdown is off so the first tick is full length.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
      end else if (!enable || wrap) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // Tick every cycle at full speed, once per period while dozing.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_q <= 1'b1;
      end else begin
         tick_q <= !enable || wrap;
      end
   end

   tick_period_a: assert property (@(posedge pclk) disable iff (!presetn)
      (enable && ratio_q == 3'h1 && tick_q && $past(enable) && $past(tick_q) == 1'b0)
      |=> !tick_q ##1 tick_q)
      else $error("slowdown tick period wrong for ratio one");

endmodule : cpu_slowdown_divider

// ==== rtl/pm_defines.svh ====
// Named offsets, field positions, reset values and timing counts of the power manager.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PM_DEFINES_SVH
`define PM_DEFINES_SVH

// Register byte offsets on the APB bus.
`define CDIV_OFFSET        8'h00
`define OSCC_OFFSET        8'h04
`define RCAUSE_OFFSET      8'h08
`define PCOFF_OFFSET       8'h0c

// Clock divider register fields.
`define WSR_BIT            15
`define RATIO_HI           14
`define RATIO_LO           12
`define SLOW_EN_BIT        11
`define RATIO_RESET        3'h0

// Oscillator control register fields.
`define NEW_OSCILLATOR_SELECT_HI            10
`define NEW_OSCILLATOR_SELECT_LO            8
`define COSC_HI            14
`define COSC_LO            12
`define LOCK_BIT           7
`define NEW_OSCILLATOR_SELECT_RESET         3'h0

// Reset cause register fields.
`define SLEEP_FLAG_BIT     3
`define IDLE_FLAG_BIT      2

// Power-save operand encoding.
`define PSAVE_OP_IDLE      1'b1

// Cycles from wake to CPU restart, lowest figure of the documented window.
`define WAKE_CYCLES        2'h2

`endif

// ==== rtl/pm_pkg.sv ====
// Types shared by the power manager and its CPU slowdown divider.
// Assumes pm_defines.svh sits on the include path.
package pm_pkg;
   `include "pm_defines.svh"

   // Power-state machine.
   typedef enum logic [2:0] {
      ST_RUN   = 3'b000,
      ST_ENTER = 3'b001,
      ST_SLEEP = 3'b010,
      ST_IDLE  = 3'b011,
      ST_WAKE  = 3'b100
   } pm_state_t;

   // Requests from the CPU core and the interrupt controller.
   typedef struct packed {
      logic psave;      // One-cycle strobe: power-save instruction executes.
      logic psave_idle; // Operand: high selects idle, low selects sleep.
      logic irq;        // Level: an individually enabled interrupt is pending.
   } core_req_t;

   // Clock enables driven out of the block.
   typedef struct packed {
      logic sys;  // System clock tree enable.
      logic cpu;  // CPU clock enable.
      logic osc;  // System oscillator enable.
      logic low_power_rc_oscillator; // Low-power RC oscillator enable.
   } clk_gate_t;
endpackage : pm_pkg

// ==== rtl/power_saving_clock_manager.sv ====
// Power manager: sleep and idle states, CPU slowdown and per-peripheral clock disables.
// Assumes an APB master on pclk, a CPU core and interrupt controller on pclk, and a
// watchdog whose timeout arrives from the low-power RC domain.
//
// Summary of operation
// - Power-save instruction enters sleep or idle, operand chooses which.
// - Sleep stops the system, CPU and oscillator clocks and all program execution.
// - Idle stops the CPU only; peripherals keep running unless disabled.
// - Enabled interrupt, watchdog timeout or device reset ends either state.
// - Sleep turns off the system oscillator; clock failure monitor is idle then.
// - Low-power RC clock keeps running in sleep while watchdog is enabled.
// - Watchdog count is cleared just before sleep is entered.
// - In sleep only externally clocked peripherals keep their clock.
// - Wake from sleep resumes on the clock source that was selected before.
// - Idle entry clears the watchdog; system clock stays running.
// - In idle the RC clock runs if watchdog or clock monitor is enabled.
// - After idle wake the CPU clock returns two to four cycles later.
// - Interrupt during the power-save instruction waits until entry completes.
// - Slowdown divides only the CPU clock; peripherals keep full speed.
// - Slowdown is active only while its enable bit eleven is set.
// - Ratio field bits 14:12 selects 1:1 to 1:128, reset 1:1.
// - With restore bit fifteen set, an interrupt ends slowdown.
// - New oscillator select bits 10:8 are writable only while unlocked.
// - Peripheral disable bit stops every clock of that peripheral.
// - Disabled peripheral registers ignore writes and read undefined.
// - Peripheral runs only if present and not disabled; present ones reset enabled.
// - Disable and re-enable each take effect one cycle later.
// - Watchdog is reset on entry to and on exit from a low-power state.
// - Bits 3 and 2 of reset cause record sleep and idle; software clears.
`timescale 1ns/10ps
`include "pm_defines.svh"

module power_saving_clock_manager
   import pm_pkg::*;
#(
   parameter int          NPERIPH     = 8,
   parameter int          OSC_W       = 3,
   parameter int          RATIO_W     = 3,
   parameter logic [7:0]  PRESENT     = 8'hff,
   parameter logic [7:0]  EXT_CLOCKED = 8'h00
)(
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB slave.
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // CPU core and interrupt controller.
   input  wire core_req_t          core_req,
   input  wire logic               wdt_timeout,
   input  wire logic               wdt_enable,
   input  wire logic               clock_failure_monitor_enable,
   input  wire logic               clock_config_locked,
   input  wire logic               clk_switch_done,
   // Clock control outputs.
   output clk_gate_t               clk_gate,
   output logic                    clock_failure_monitor_active,
   output logic                    wdt_clear,
   output logic                    cpu_resume,
   output logic [OSC_W-1:0]        osc_request,
   output logic [NPERIPH-1:0]      periph_clk_en,
   output logic [NPERIPH-1:0]      periph_reg_en
);

   pm_state_t            state_q, state_d;
   logic                 mode_idle_q;
   logic [1:0]           wake_cnt_q;
   logic                 to_s1_q, to_s2_q;
   logic                 wake_evt;
   logic [3:0]           sel;
   logic                 setup, wr_en;
   logic                 slow_en_q, wsr_q;
   logic [RATIO_W-1:0]   ratio_q;
   logic [OSC_W-1:0]     new_oscillator_select_q, cosc_q;
   logic                 sleep_flag_q, idle_flag_q;
   logic [NPERIPH-1:0]   pcoff_q;
   logic                 tick;
   logic                 enter_now, wake_now;

   // One-hot register select from the byte address; used by both read and write paths.
   function automatic logic [3:0] reg_sel(input logic [7:0] a);
      reg_sel = {a == `PCOFF_OFFSET, a == `RCAUSE_OFFSET, a == `OSCC_OFFSET, a == `CDIV_OFFSET};
   endfunction : reg_sel

   assign sel   = reg_sel(paddr);
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pready && pwrite;

   // Timeout comes from the RC domain and passes two flops before anything reads it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         to_s1_q <= 1'b0;
         to_s2_q <= 1'b0;
      end else begin
         to_s1_q <= wdt_timeout;
         to_s2_q <= to_s1_q;
      end
   end

   assign wake_evt = core_req.irq || to_s2_q;

   // Next state. Interrupts are not looked at in ENTER, so a coincident one waits for entry.
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_RUN:   if (core_req.psave) state_d = ST_ENTER;
         ST_ENTER: state_d = mode_idle_q ? ST_IDLE : ST_SLEEP;
         ST_SLEEP: if (wake_evt) state_d = ST_WAKE;
         ST_IDLE:  if (wake_evt) state_d = ST_WAKE;
         ST_WAKE:  if (wake_cnt_q == `WAKE_CYCLES - 2'h1) state_d = ST_RUN;
         default:  state_d = ST_RUN;
      endcase
   end

   assign enter_now = (state_d == ST_ENTER) && (state_q != ST_ENTER);
   assign wake_now  = (state_d == ST_WAKE) && (state_q != ST_WAKE);

   // State register; device reset always lands in RUN.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // Operand is captured with the instruction strobe.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_idle_q <= 1'b0;
      end else if (state_q == ST_RUN && core_req.psave) begin
         mode_idle_q <= (core_req.psave_idle == `PSAVE_OP_IDLE);
      end
   end

   // Wake delay counter.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_cnt_q <= 2'h0;
      end else if (state_q == ST_WAKE) begin
         wake_cnt_q <= wake_cnt_q + 2'h1;
      end else begin
         wake_cnt_q <= 2'h0;
      end
   end

   // Watchdog clear pulses on entry and on wake; resume pulses on return to RUN.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_clear  <= 1'b0;
         cpu_resume <= 1'b0;
      end else begin
         wdt_clear  <= enter_now || wake_now;
         cpu_resume <= (state_q == ST_WAKE) && (state_d == ST_RUN);
      end
   end

   // Clock enables are registered from the next state, so they switch only at an edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_gate    <= '{sys: 1'b1, cpu: 1'b1, osc: 1'b1, low_power_rc_oscillator: 1'b0};
         clock_failure_monitor_active <= 1'b0;
      end else begin
         clk_gate.sys  <= (state_d != ST_SLEEP);
         clk_gate.osc  <= (state_d != ST_SLEEP);
         clk_gate.cpu  <= (state_d == ST_RUN) && tick;
         clk_gate.low_power_rc_oscillator <= wdt_enable || (clock_failure_monitor_enable && state_d != ST_SLEEP);
         clock_failure_monitor_active   <= clock_failure_monitor_enable && (state_d != ST_SLEEP);
      end
   end

   // Peripheral gating lags the disable register by one cycle; sleep keeps only external clocks.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         periph_clk_en <= PRESENT[NPERIPH-1:0];
         periph_reg_en <= PRESENT[NPERIPH-1:0];
      end else begin
         for (int i = 0; i < NPERIPH; i++) begin
            periph_reg_en[i] <= PRESENT[i] && !pcoff_q[i];
            periph_clk_en[i] <= PRESENT[i] && !pcoff_q[i] &&
                                ((state_d != ST_SLEEP) || EXT_CLOCKED[i]);
         end
      end
   end

   // CPU slowdown tick generator.
   cpu_slowdown_divider #(
      .RATIO_W (RATIO_W),
      .CNT_W   ((1 << RATIO_W) - 1)
   ) u_div (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (slow_en_q),
      .ratio   (ratio_q),
      .tick_q  (tick)
   );

   // Clock divider register. An interrupt with restore set wins over a same-cycle write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_en_q <= 1'b0;
         wsr_q     <= 1'b0;
         ratio_q   <= `RATIO_RESET;
      end else begin
         if (wr_en && sel[0]) begin
            wsr_q     <= pwdata[`WSR_BIT];
            ratio_q   <= pwdata[`RATIO_HI:`RATIO_LO];
            slow_en_q <= pwdata[`SLOW_EN_BIT];
         end
         if (wsr_q && core_req.irq && slow_en_q) begin
            slow_en_q <= 1'b0;
         end
      end
   end

   // Oscillator select: writable only while unlocked; the active source changes only on a
   // completed switch, so sleep never alters it and wake resumes on the same source.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         new_oscillator_select_q      <= `NEW_OSCILLATOR_SELECT_RESET;
         cosc_q      <= `NEW_OSCILLATOR_SELECT_RESET;
         osc_request <= `NEW_OSCILLATOR_SELECT_RESET;
      end else begin
         if (wr_en && sel[1] && !clock_config_locked) begin
            new_oscillator_select_q <= pwdata[`NEW_OSCILLATOR_SELECT_HI:`NEW_OSCILLATOR_SELECT_LO];
         end
         if (clk_switch_done) begin
            cosc_q <= new_oscillator_select_q;
         end
         osc_request <= new_oscillator_select_q;
      end
   end

   // Entry flags: hardware set wins over a same-cycle software write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_flag_q <= 1'b0;
         idle_flag_q  <= 1'b0;
      end else begin
         if (wr_en && sel[2]) begin
            sleep_flag_q <= pwdata[`SLEEP_FLAG_BIT];
            idle_flag_q  <= pwdata[`IDLE_FLAG_BIT];
         end
         if (state_q == ST_ENTER && !mode_idle_q) begin
            sleep_flag_q <= 1'b1;
         end
         if (state_q == ST_ENTER && mode_idle_q) begin
            idle_flag_q <= 1'b1;
         end
      end
   end

   // Peripheral disable bits; absent peripherals always read back as disabled.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pcoff_q <= ~PRESENT[NPERIPH-1:0];
      end else if (wr_en && sel[3]) begin
         pcoff_q <= pwdata[NPERIPH-1:0] | ~PRESENT[NPERIPH-1:0];
      end
   end

   // APB answer is prepared in the setup cycle so the access phase completes at once.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= setup;
         pslverr <= setup && (sel == 4'h0);
         prdata  <= 32'h0;
         if (setup && !pwrite) begin
            case (sel)
               4'h1: begin
                  prdata[`WSR_BIT]              <= wsr_q;
                  prdata[`RATIO_HI:`RATIO_LO]   <= ratio_q;
                  prdata[`SLOW_EN_BIT]          <= slow_en_q;
               end
               4'h2: begin
                  prdata[`COSC_HI:`COSC_LO]     <= cosc_q;
                  prdata[`NEW_OSCILLATOR_SELECT_HI:`NEW_OSCILLATOR_SELECT_LO]     <= new_oscillator_select_q;
                  prdata[`LOCK_BIT]             <= clock_config_locked;
               end
               4'h4: begin
                  prdata[`SLEEP_FLAG_BIT]       <= sleep_flag_q;
                  prdata[`IDLE_FLAG_BIT]        <= idle_flag_q;
               end
               4'h8:    prdata[NPERIPH-1:0]     <= pcoff_q;
               default: prdata                  <= 32'h0;
            endcase
         end
      end
   end

   enter_from_run_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_RUN && core_req.psave) |=> state_q == ST_ENTER)
      else $error("power-save strobe did not start entry");

   sleep_clocks_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_SLEEP) |-> !clk_gate.sys && !clk_gate.cpu && !clk_gate.osc && !clock_failure_monitor_active)
      else $error("a clock still runs in sleep");

   idle_sys_on_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_IDLE) |-> clk_gate.sys && clk_gate.osc && !clk_gate.cpu)
      else $error("idle gating wrong");

   wake_on_event_a: assert property (@(posedge pclk) disable iff (!presetn)
      ((state_q == ST_SLEEP || state_q == ST_IDLE) && core_req.irq) |=> state_q == ST_WAKE)
      else $error("interrupt did not wake the device");

   entry_deferred_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_ENTER) |=> (state_q == ST_SLEEP || state_q == ST_IDLE))
      else $error("entry did not complete before wake");

   resume_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_WAKE && $past(state_q) != ST_WAKE) |-> state_q == ST_WAKE ##2 state_q == ST_RUN)
      else $error("resume delay not two cycles");

   entry_clears_wdt_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_ENTER) |-> wdt_clear ##1 !wdt_clear)
      else $error("watchdog not cleared on entry");

   wake_clears_wdt_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_WAKE && $past(state_q) != ST_WAKE) |-> wdt_clear)
      else $error("watchdog not cleared on wake");

   entry_flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_ENTER) |=> (mode_idle_q ? idle_flag_q : sleep_flag_q))
      else $error("entry flag not recorded");

   rc_kept_sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_SLEEP && $past(wdt_enable)) |-> clk_gate.low_power_rc_oscillator)
      else $error("rc clock stopped with watchdog enabled");

   locked_select_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && sel[1] && clock_config_locked) |=> $stable(new_oscillator_select_q))
      else $error("oscillator select changed while locked");

   periph_off_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(pcoff_q[0]) |-> periph_reg_en[0] ##1 !periph_reg_en[0] && !periph_clk_en[0])
      else $error("peripheral disable delay wrong");

   restore_on_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wsr_q && slow_en_q && core_req.irq) |=> !slow_en_q)
      else $error("interrupt did not end slowdown");

endmodule : power_saving_clock_manager
